/* verilog/rsss_supervisor.sv */
// range select and status supervisor top
// assumes switch, comparator and checksum inputs are asynchronous
//
// Chosen here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
module rsss_supervisor
  import rsss_pkg::*;
#(
  parameter int SLOW_CYC = RSSS_SLOW_CYC,
  parameter int FAST_CYC = RSSS_FAST_CYC,
  parameter int SHORT_CYC = RSSS_SHORT_CYC,
  parameter int RECAL_CYC = RSSS_RECAL_CYC
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [9:0] config_switch_bank,
  input wire logic current_fullscale_selector,
  input wire logic cksum_done,
  input wire logic factory_cksum_bad,
  input wire logic field_cksum_bad,
  input wire logic under_range,
  input wire logic over_range,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic led_red,
  output logic led_green,
  output logic out_force_zero,
  output logic out_force_min,
  output logic out_clamp_overrange,
  output logic [2:0] out_range_code,
  output logic [4:0] in_range_code,
  output logic in_is_current,
  output logic out_fullscale_20ma,
  output logic in_use_field,
  output logic out_use_field,
  output logic store_factory_as_field
);

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  localparam int NSYNC = 16;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  wire [NSYNC-1:0] raw_in = {config_switch_bank, current_fullscale_selector, cksum_done,
    factory_cksum_bad, field_cksum_bad, under_range, over_range};

  // two stages, only stage two is read
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  wire [9:0] sw = sync2_r[15:6];
  wire fs_sel = sync2_r[5];
  wire ck_done = sync2_r[4];
  wire fac_bad_in = sync2_r[3];
  wire fld_bad_in = sync2_r[2];
  wire und_s = sync2_r[1];
  wire ovr_s = sync2_r[0];

  // ----------------------------------------------------------------
  // range decode
  // ----------------------------------------------------------------
  // position 3 is the code msb
  function automatic logic [2:0] out_code_f(input logic [9:0] s);
    out_code_f = {s[2], s[3], s[4]};
  endfunction
  // position 6 is the code msb
  function automatic logic [4:0] in_code_f(input logic [9:0] s);
    in_code_f = {s[5], s[6], s[7], s[8], s[9]};
  endfunction

  wire [2:0] out_code_now = out_code_f(sw);
  wire [4:0] in_code_now = in_code_f(sw);
  wire codes_ok = (out_code_now <= RSSS_OUT_CODE_MAX) && (in_code_now <= RSSS_IN_CODE_MAX);

  // ----------------------------------------------------------------
  // supervisor state
  // ----------------------------------------------------------------
  rsss_state_t state_r;
  rsss_state_t state_nxt;
  logic [7:0] range_snap_r;
  logic fac_bad_r;
  logic fld_bad_r;
  logic in_sel_boot_r;
  logic out_sel_boot_r;
  logic in_sel_prev_r;
  logic out_sel_prev_r;
  logic scaling_r;
  logic scale_bad_r;
  logic clr_req;
  logic recal_req;
  wire range_moved = sw[RSSS_SW_RANGE_HI:RSSS_SW_RANGE_LO] != range_snap_r;

  // next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RSSS_BOOT: begin
        if (ck_done) begin
          state_nxt = codes_ok ? RSSS_RUN : RSSS_BADRANGE;
        end
      end
      RSSS_BADRANGE: state_nxt = RSSS_BADRANGE;
      RSSS_RUN: begin
        if (range_moved) begin
          state_nxt = RSSS_CHANGED;
        end
      end
      RSSS_CHANGED: begin
        if (!range_moved) begin
          state_nxt = RSSS_RUN;
        end
      end
      default: state_nxt = RSSS_BOOT;
    endcase
  end

  // power-up capture happens while booting, never under reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_r <= RSSS_BOOT;
      range_snap_r <= '0;
      in_sel_boot_r <= 1'b0;
      out_sel_boot_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (state_r == RSSS_BOOT) begin
        range_snap_r <= sw[RSSS_SW_RANGE_HI:RSSS_SW_RANGE_LO];
        in_sel_boot_r <= sw[RSSS_SW_IN_SEL];
        out_sel_boot_r <= sw[RSSS_SW_OUT_SEL];
      end
    end
  end

  // checksum flags latched per set, set beats clear
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fac_bad_r <= 1'b0;
      fld_bad_r <= 1'b0;
    end else if (state_r == RSSS_BOOT && ck_done) begin
      fac_bad_r <= fac_bad_in;
      fld_bad_r <= fld_bad_in;
    end else if (clr_req) begin
      fac_bad_r <= 1'b0;
      fld_bad_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // calibration source selection
  // ----------------------------------------------------------------
  // selector memory: once dropped to factory stays factory until reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      in_sel_prev_r <= 1'b0;
      out_sel_prev_r <= 1'b0;
    end else if (state_r == RSSS_BOOT) begin
      in_sel_prev_r <= sw[RSSS_SW_IN_SEL];
      out_sel_prev_r <= sw[RSSS_SW_OUT_SEL];
    end else begin
      in_sel_prev_r <= in_sel_prev_r & (sw[RSSS_SW_IN_SEL] | scaling_r);
      out_sel_prev_r <= out_sel_prev_r & (sw[RSSS_SW_OUT_SEL] | scaling_r);
    end
  end

  // per channel choice from its own switch
  rsss_cal_sel_t sel_raw;
  assign sel_raw.in_field = in_sel_boot_r & in_sel_prev_r;
  assign sel_raw.out_field = out_sel_boot_r & out_sel_prev_r;
  rsss_cal_sel_t sel_fin;
  assign sel_fin.in_field = fac_bad_r | (~fld_bad_r & sel_raw.in_field);
  assign sel_fin.out_field = fac_bad_r | (~fld_bad_r & sel_raw.out_field);

  // ----------------------------------------------------------------
  // register bus, writes at once, reads one wait state
  // ----------------------------------------------------------------
  wire wr_ctrl = avs_write && avs_address == RSSS_REG_CTRL && avs_byteenable[0];
  // software sets the scaling level regardless of factory error
  assign clr_req = wr_ctrl && avs_writedata[RSSS_CTRL_CLR_CKSUM];
  assign recal_req = wr_ctrl && avs_writedata[RSSS_CTRL_RECAL_DONE];

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      scaling_r <= 1'b0;
      scale_bad_r <= 1'b0;
    end else if (wr_ctrl) begin
      scaling_r <= avs_writedata[RSSS_CTRL_SCALING];
      scale_bad_r <= avs_writedata[RSSS_CTRL_SCALE_BAD];
    end
  end

  wire [31:0] status_word = {24'h000000, und_s, ovr_s, fld_bad_r, fac_bad_r,
    state_r == RSSS_CHANGED, state_r == RSSS_BADRANGE, sel_fin.in_field,
    sel_fin.out_field};
  wire [31:0] rd_mux = (avs_address == RSSS_REG_STATUS) ? status_word :
    (avs_address == RSSS_REG_CTRL) ? {29'h0, scale_bad_r, 1'b0, scaling_r} :
    (avs_address == RSSS_REG_RANGE) ? {24'h000000, range_snap_r} : 32'h00000000;

  // one wait state on reads so read data leave a flop; unmapped reads as zero
  logic rd_hold_r;
  logic [31:0] rd_data_r;
  assign avs_waitrequest = avs_read && !rd_hold_r;
  assign avs_readdata = rd_data_r;

  // data latched on the waiting edge, shown until the accepting one
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_hold_r <= 1'b0;
      rd_data_r <= 32'h00000000;
    end else begin
      rd_hold_r <= avs_waitrequest;
      if (avs_waitrequest) begin
        rd_data_r <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // LED timers, separate slow, fast and recal counters at the core clock
  // ----------------------------------------------------------------
  logic [31:0] slow_cnt_r;
  logic [31:0] fast_cnt_r;
  logic [31:0] recal_cnt_r;
  logic slow_ph_r;
  logic fast_ph_r;
  wire slow_wrap = slow_cnt_r >= 32'(SLOW_CYC / 2 - 1);
  wire fast_wrap = fast_cnt_r >= 32'(FAST_CYC / 2 - 1);
  // short off at the end of each slow period
  wire short_off = slow_ph_r && slow_cnt_r >= 32'(SLOW_CYC / 2 - SHORT_CYC);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slow_cnt_r <= '0;
      fast_cnt_r <= '0;
      slow_ph_r <= 1'b0;
      fast_ph_r <= 1'b0;
    end else begin
      slow_cnt_r <= slow_wrap ? 32'h0 : slow_cnt_r + 32'h1;
      fast_cnt_r <= fast_wrap ? 32'h0 : fast_cnt_r + 32'h1;
      slow_ph_r <= slow_ph_r ^ slow_wrap;
      fast_ph_r <= fast_ph_r ^ fast_wrap;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      recal_cnt_r <= '0;
    end else if (recal_req) begin
      recal_cnt_r <= 32'(RECAL_CYC);
    end else if (recal_cnt_r != 32'h0) begin
      recal_cnt_r <= recal_cnt_r - 32'h1;
    end
  end

  // ----------------------------------------------------------------
  // LED priority
  // ----------------------------------------------------------------
  rsss_led_t led_nxt;
  always_comb begin
    led_nxt = '{red: 1'b0, green: 1'b1}; // normal green
    if (fac_bad_r) begin
      led_nxt = '{red: ~short_off, green: 1'b0};
    end else if (fld_bad_r) begin
      led_nxt = '{red: 1'b0, green: ~short_off};
    end else if (state_r == RSSS_BADRANGE || state_r == RSSS_CHANGED || state_r == RSSS_BOOT) begin
      led_nxt = '{red: state_r != RSSS_BOOT, green: 1'b0};
    end else if (recal_cnt_r != 32'h0) begin
      led_nxt = '{red: 1'b0, green: fast_ph_r};
    end else if (scaling_r) begin
      led_nxt = '{red: slow_ph_r, green: ~slow_ph_r};
    end else if (ovr_s && !und_s) begin
      led_nxt = '{red: fast_ph_r, green: 1'b0};
    end else if (und_s) begin
      led_nxt = '{red: slow_ph_r, green: 1'b0};
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      led_red <= 1'b0;
      led_green <= 1'b0;
      out_force_zero <= 1'b1;
      out_force_min <= 1'b0;
      out_range_code <= '0;
      in_range_code <= '0;
      in_is_current <= 1'b0;
      out_fullscale_20ma <= 1'b0;
      in_use_field <= 1'b0;
      out_use_field <= 1'b0;
      store_factory_as_field <= 1'b0;
    end else begin
      led_red <= led_nxt.red;
      led_green <= led_nxt.green;
      out_force_zero <= state_r != RSSS_RUN && state_r != RSSS_CHANGED;
      out_force_min <= state_r == RSSS_CHANGED;
      out_range_code <= {range_snap_r[0], range_snap_r[1], range_snap_r[2]};
      in_range_code <= {range_snap_r[3], range_snap_r[4], range_snap_r[5], range_snap_r[6],
        range_snap_r[7]};
      in_is_current <= {range_snap_r[3], range_snap_r[4], range_snap_r[5], range_snap_r[6],
        range_snap_r[7]} > RSSS_IN_VOLT_MAX;
      out_fullscale_20ma <= fs_sel;
      in_use_field <= sel_fin.in_field;
      out_use_field <= sel_fin.out_field;
      store_factory_as_field <= scale_bad_r;
    end
  end

  assign out_clamp_overrange = 1'b1;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  badrange_stick_a: assert property (@(posedge core_clk) disable iff (rst)
    state_r == RSSS_BADRANGE |=> state_r == RSSS_BADRANGE)
    else $error("invalid range state left");
  badrange_led_a: assert property (@(posedge core_clk) disable iff (rst)
    state_r == RSSS_BADRANGE && !fac_bad_r && !fld_bad_r |=> led_red && !led_green
    && out_force_zero) else $error("invalid range indication wrong");
  change_min_a: assert property (@(posedge core_clk) disable iff (rst)
    state_r == RSSS_RUN && range_moved |=> ##1 out_force_min)
    else $error("range change not caught");
  change_back_a: assert property (@(posedge core_clk) disable iff (rst)
    state_r == RSSS_CHANGED && !range_moved |=> state_r == RSSS_RUN)
    else $error("range change not released");
  fld_bad_sel_a: assert property (@(posedge core_clk) disable iff (rst)
    fld_bad_r && !fac_bad_r |=> !in_use_field && !out_use_field)
    else $error("field used despite field error");
  fac_bad_sel_a: assert property (@(posedge core_clk) disable iff (rst)
    fac_bad_r |=> in_use_field && out_use_field)
    else $error("factory used despite factory error");
  cksum_led_a: assert property (@(posedge core_clk) disable iff (rst)
    fac_bad_r |=> !led_green) else $error("factory error led wrong");
  fs_sel_a: assert property (@(posedge core_clk) disable iff (rst)
    out_fullscale_20ma == $past(fs_sel)) else $error("full scale select wrong");
  normal_led_a: assert property (@(posedge core_clk) disable iff (rst)
    state_r == RSSS_RUN && !fac_bad_r && !fld_bad_r && !scaling_r && !und_s
    && !ovr_s && recal_cnt_r == 32'h0 |=> led_green && !led_red)
    else $error("normal led wrong");
  und_led_a: assert property (@(posedge core_clk) disable iff (rst)
    state_r == RSSS_RUN && und_s && !fac_bad_r && !fld_bad_r && !scaling_r
    && recal_cnt_r == 32'h0 |=> !led_green && led_red == $past(slow_ph_r))
    else $error("under range led wrong");
  ovr_led_a: assert property (@(posedge core_clk) disable iff (rst)
    state_r == RSSS_RUN && ovr_s && !und_s && !fac_bad_r && !fld_bad_r && !scaling_r
    && recal_cnt_r == 32'h0 |=> !led_green && led_red == $past(fast_ph_r))
    else $error("over range led wrong");
  ovr_c: cover property (@(posedge core_clk) state_r == RSSS_RUN && ovr_s && !und_s);
  recal_c: cover property (@(posedge core_clk) recal_cnt_r == 32'h1);
  boot_c: cover property (@(posedge core_clk) state_r == RSSS_BOOT ##1 state_r == RSSS_RUN);
  bad_c: cover property (@(posedge core_clk) state_r == RSSS_BADRANGE);
  chg_c: cover property (@(posedge core_clk) state_r == RSSS_CHANGED ##1 state_r == RSSS_RUN);
endmodule

/* verilog/rsss_pkg.sv */
// range select and status supervisor: shared constants and carriers
// assumes one 100 MHz core clock and an Avalon-MM register master
// ----------------------------------------------------------------
// What this block does
// - invalid range at power-up: zero output, red
// - invalid range error held until power cycle
// - running switch 3-10 change: minimum output, red
// - range change error clears when switches restored
// - check both calibration sets at power-up
// - field checksum bad: factory values only
// - factory checksum bad: field values only
// - checksum error LEDs win, blink short off
// - under range: green off, red 0.8 s
// - over range: green off, red 0.4 s
// - scaling: red and green alternate
// - factory recal done: green fast 2 s
// - output code from switches 3,4,5
// - input code from switches 6 to 10
// - field selector at power-up loads field
// - factory selector at power-up loads factory
// - field to factory while running, not scaling, switches now
// - current full scale 20 mA on, 1 mA off
// - output clamped at ten percent overrange
// - bad field scaling stores factory values
// - switch 1 output, switch 2 input selector
// ----------------------------------------------------------------
package rsss_pkg;
  // register byte offsets
  localparam logic [3:0] RSSS_REG_STATUS = 4'h0;
  localparam logic [3:0] RSSS_REG_CTRL = 4'h4;
  localparam logic [3:0] RSSS_REG_RANGE = 4'h8;
  // control fields
  localparam int RSSS_CTRL_SCALING = 0;
  localparam int RSSS_CTRL_RECAL_DONE = 1;
  localparam int RSSS_CTRL_SCALE_BAD = 2;
  localparam int RSSS_CTRL_CLR_CKSUM = 3;
  // switch positions inside the bank, bit n-1 is position n
  localparam int RSSS_SW_OUT_SEL = 0;
  localparam int RSSS_SW_IN_SEL = 1;
  localparam int RSSS_SW_RANGE_LO = 2;
  localparam int RSSS_SW_RANGE_HI = 9;
  // range code limits
  localparam logic [2:0] RSSS_OUT_CODE_MAX = 3'h4;
  localparam logic [4:0] RSSS_IN_CODE_MAX = 5'h14;
  localparam logic [4:0] RSSS_IN_VOLT_MAX = 5'h0C;
  // timing, times in ms
  localparam int RSSS_CLK_KHZ = 100000;
  localparam int RSSS_SLOW_MS = 800;
  localparam int RSSS_FAST_MS = 400;
  localparam int RSSS_SHORT_OFF_MS = 100;
  localparam int RSSS_RECAL_MS = 2000;
  localparam int RSSS_SLOW_CYC = RSSS_SLOW_MS * RSSS_CLK_KHZ;
  localparam int RSSS_FAST_CYC = RSSS_FAST_MS * RSSS_CLK_KHZ;
  localparam int RSSS_SHORT_CYC = RSSS_SHORT_OFF_MS * RSSS_CLK_KHZ;
  localparam int RSSS_RECAL_CYC = RSSS_RECAL_MS * RSSS_CLK_KHZ;
  typedef enum {RSSS_BOOT, RSSS_RUN, RSSS_BADRANGE, RSSS_CHANGED} rsss_state_t;
  // calibration source per channel
  typedef struct packed {
    logic in_field;
    logic out_field;
  } rsss_cal_sel_t;
  // LED pair
  typedef struct packed {
    logic red;
    logic green;
  } rsss_led_t;
endpackage

/* dv/rsss_far_side.sv */
// far side model: switch bank, input comparator and calibration store
// assumes the bench sets the wanted levels; all outputs move on the rising edge
`timescale 1ns/1ns
module rsss_far_side #(
  parameter int CK_DELAY = 12
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [9:0] sw_set,
  input wire logic [4:0] lvl_set,
  output logic [9:0] config_switch_bank = 10'h000,
  output logic current_fullscale_selector = 1'b0,
  output logic cksum_done = 1'b0,
  output logic factory_cksum_bad = 1'b0,
  output logic field_cksum_bad = 1'b0,
  output logic under_range = 1'b0,
  output logic over_range = 1'b0
);
  int wait_r = 0;
  // ----------------------------------------------------------------
  // switches and comparator
  // ----------------------------------------------------------------
  // ranges move only where a scenario commands it
  always @(posedge core_clk) begin
    config_switch_bank <= sw_set;
    current_fullscale_selector <= lvl_set[4];
    under_range <= lvl_set[3];
    over_range <= lvl_set[2];
  end
  // ----------------------------------------------------------------
  // calibration store
  // ----------------------------------------------------------------
  // results valid only once the store has been read back
  // flags toggle until then, so a design that samples early sees junk
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wait_r <= 0;
      cksum_done <= 1'b0;
    end else if (wait_r < CK_DELAY) begin
      wait_r <= wait_r + 1;
      factory_cksum_bad <= ~factory_cksum_bad;
      field_cksum_bad <= ~field_cksum_bad;
    end else begin
      cksum_done <= 1'b1;
      factory_cksum_bad <= lvl_set[1];
      field_cksum_bad <= lvl_set[0];
    end
  end
endmodule

/* dv/tb_top.sv */
// bench for the range select and status supervisor
// assumes the far side model and the package; shortened blink counts
`timescale 1ns/1ns
module tb_top;
  import rsss_pkg::*;
  localparam int SLOW = 80;
  localparam int FAST = 40;
  localparam int RECAL = 200;
  localparam int CKD = 12;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] sw_set = 10'h000;
  logic [4:0] lvl_set = 5'h00;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hF;
  logic [9:0] config_switch_bank;
  logic current_fullscale_selector, cksum_done, factory_cksum_bad, field_cksum_bad;
  logic under_range, over_range, avs_waitrequest, led_red, led_green;
  logic out_force_zero, out_force_min, out_clamp_overrange, in_is_current;
  logic out_fullscale_20ma, in_use_field, out_use_field, store_factory_as_field;
  logic [31:0] avs_readdata;
  logic [2:0] out_range_code;
  logic [4:0] in_range_code;
  logic [31:0] rd_cap = 32'h0;
  logic [7:0] meas = 8'h00;
  logic [31:0] seed = 32'h0000000E;
  logic [115:0] exp_q[$];
  int error_cnt = 0;
  int compares = 0;
  int rt, gt, rh, gh, same, tu;
  event look;
  wire [57:0] obs = {meas, rd_cap, store_factory_as_field, out_clamp_overrange, led_red,
    led_green, out_force_zero, out_force_min, out_range_code, in_range_code, in_is_current,
    out_fullscale_20ma, in_use_field, out_use_field};

  rsss_far_side #(.CK_DELAY(CKD)) far (.core_clk, .rst, .sw_set, .lvl_set,
    .config_switch_bank, .current_fullscale_selector, .cksum_done, .factory_cksum_bad,
    .field_cksum_bad, .under_range, .over_range);
  rsss_supervisor #(.SLOW_CYC(SLOW), .FAST_CYC(FAST), .SHORT_CYC(10), .RECAL_CYC(RECAL)) dut (
    .core_clk, .rst, .config_switch_bank, .current_fullscale_selector, .cksum_done,
    .factory_cksum_bad, .field_cksum_bad, .under_range, .over_range, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .led_red,
    .led_green, .out_force_zero, .out_force_min, .out_clamp_overrange, .out_range_code,
    .in_range_code, .in_is_current, .out_fullscale_20ma, .in_use_field, .out_use_field,
    .store_factory_as_field);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // position 3 and position 6 are the code msbs, so bits run reversed
  function automatic logic [9:0] mk(input logic [2:0] oc, input logic [4:0] ic,
                                    input logic [1:0] sel);
    return {ic[0], ic[1], ic[2], ic[3], ic[4], oc[0], oc[1], oc[2], sel};
  endfunction
  task automatic check(input logic [57:0] seen, input logic [57:0] expv);
    compares++;
    if (seen !== expv) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, expv);
    end
  endtask
  task automatic close_out();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // the note goes on the queue, the monitor takes it off
  task automatic note(input logic [57:0] m, input logic [57:0] v);
    exp_q.push_back({m, v});
    ->look;
    #1;
  endtask
  always @(look) begin : mon
    logic [115:0] e;
    e = exp_q.pop_front();
    check(obs & e[115:58], e[57:0] & e[115:58]);
  end
  task automatic out(input logic [17:0] m, input logic [17:0] v);
    note({40'h0, m}, {40'h0, v});
  endtask
  task automatic mt(input logic [7:0] m, input logic [7:0] s);
    meas = s;
    note({m, 50'h0}, {m, 50'h0});
  endtask
  // switches cross two sync flops, a few edges cover that
  task automatic drive(input logic [9:0] sw, input logic [4:0] lv);
    @(posedge core_clk);
    sw_set <= sw;
    lvl_set <= lv;
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic power(input logic [9:0] sw, input logic [4:0] lv);
    @(posedge core_clk);
    sw_set <= sw;
    lvl_set <= lv;
    rst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    repeat (CKD + 8) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0 && n < 50) begin
      n++;
      @(posedge core_clk);
    end
    if (n == 50) begin
      error_cnt++;
      close_out();
    end
    rd_cap = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task automatic watch(input int n);
    logic pr, pg;
    rt = 0;
    gt = 0;
    rh = 0;
    gh = 0;
    same = 0;
    pr = led_red;
    pg = led_green;
    repeat (n) begin
      @(negedge core_clk);
      rt += int'(led_red !== pr);
      gt += int'(led_green !== pg);
      rh += int'(led_red === 1'b1);
      gh += int'(led_green === 1'b1);
      same += int'(led_red === led_green);
      pr = led_red;
      pg = led_green;
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (90000) @(posedge core_clk);
    error_cnt++;
    close_out();
  end
  initial begin : main
    logic [4:0] ic;
    logic [9:0] sw;
    logic [4:0] lv;
    // valid power-ups, every output code, input boundaries and random picks
    for (int i = 0; i < 5; i++) begin
      ic = (i == 0) ? 5'h14 : (i == 1) ? 5'h0C : (i == 2) ? 5'h0D : 5'(rnd() % 21);
      sw = mk(3'(i), ic, 2'(rnd()));
      lv = {1'(rnd()), 4'h0};
      power(sw, lv);
      out(18'h3FFFF, {2'b01, 4'b0100, 3'(i), ic, ic > RSSS_IN_VOLT_MAX, lv[4], sw[1:0]});
    end
    // invalid codes, then valid switches without a power cycle
    for (int i = 0; i < 4; i++) begin
      power((i < 3) ? mk(3'(5 + i), 5'h00, 2'b00) : mk(3'h0, 5'h15, 2'b00), 5'h00);
      out(18'h0E000, 18'h0A000);
      drive(mk(3'h0, 5'h00, 2'b00), 5'h00);
      out(18'h0E000, 18'h0A000);
    end
    // each range position changed while running, then put back
    sw = mk(3'h1, 5'h09, 2'b00);
    power(sw, 5'h00);
    for (int j = 2; j < 10; j++) begin
      drive(sw ^ (10'h001 << j), 5'h00);
      out(18'h0D000, 18'h09000);
      drive(sw, 5'h00);
      out(18'h0D000, 18'h04000);
    end
    power(mk(3'h1, 5'h09, 2'b11), 5'h00);
    out(18'h00003, 18'h00003);
    drive(mk(3'h1, 5'h09, 2'b00), 5'h00);
    out(18'h0C003, 18'h04000);
    // field store bad with under range pending: field blink must win
    power(mk(3'h1, 5'h09, 2'b11), 5'h09);
    out(18'h00003, 18'h00000);
    watch(200);
    mt(8'h07, {5'h0, rh == 0, gt > 0, gh > 100});
    power(mk(3'h1, 5'h09, 2'b00), 5'h02);
    out(18'h00003, 18'h00003);
    watch(200);
    mt(8'h07, {5'h0, gh == 0, rt > 0, rh > 100});
    bus(1'b0, RSSS_REG_STATUS, 32'h0);
    note({8'h0, 32'h00000030, 18'h0}, {8'h0, 32'h00000010, 18'h0});
    bus(1'b1, RSSS_REG_CTRL, 32'h00000008);
    out(18'h0C000, 18'h04000);
    bus(1'b0, RSSS_REG_STATUS, 32'h0);
    note({8'h0, 32'h00000030, 18'h0}, 58'h0);
    bus(1'b0, 4'hC, 32'h0);
    note({8'h0, 32'hFFFFFFFF, 18'h0}, 58'h0);
    // under then over range: the fast rate toggles more often
    sw = mk(3'h1, 5'h09, 2'b00);
    power(sw, 5'h08);
    watch(8 * FAST);
    tu = rt;
    mt(8'h03, {6'h0, gh == 0, rt > 1});
    drive(sw, 5'h04);
    watch(8 * FAST);
    mt(8'h03, {6'h0, gh == 0, rt > tu});
    drive(sw, 5'h00);
    // scaling begun with both stores good
    bus(1'b1, RSSS_REG_CTRL, 32'h00000001);
    watch(200);
    mt(8'h03, {6'h0, same == 0, rt > 1});
    bus(1'b1, RSSS_REG_CTRL, 32'h00000002);
    watch(100);
    mt(8'h03, {6'h0, rh == 0, gt > 1});
    repeat (RECAL) @(negedge core_clk);
    out(18'h0C000, 18'h04000);
    bus(1'b1, RSSS_REG_CTRL, 32'h00000004);
    out(18'h20000, 18'h20000);
    close_out();
  end
endmodule
